// ==== core/lead_derive.sv ====
// Purpose: forms one pace lead from the three raw channel samples
// Assumes: samples are the decimated 128 kHz words, not the output frame data
// Notes: 18-bit result so differences and half-sums never wrap
module lead_derive (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_sync_n,
   // samples and configuration
   input pace_pkg::chan_smp_t smp,
   input wire logic smp_valid,
   input pace_pkg::lead_cfg_t cfg,
   // derived lead
   output logic signed [17:0] lead_q,
   output logic lead_valid_q
);
   logic signed [17:0] c1, c2, c3, lead_d;

   // lead arithmetic per front-end configuration
   always_comb
   begin
      c1 = 18'(smp.ch1);
      c2 = 18'(smp.ch2);
      c3 = 18'(smp.ch3);
      lead_d = c1;
      unique case (cfg.sel)
         pace_pkg::LEAD_I:
            lead_d = (cfg.chcfg || cfg.ceref) ? c1 : c1 - c3;
         pace_pkg::LEAD_II:
            lead_d = cfg.chcfg ? -c3 : (cfg.ceref ? c2 : c2 - c3);
         pace_pkg::LEAD_III:
            lead_d = cfg.chcfg ? c2 : c2 - c1;
         pace_pkg::LEAD_AVF:
            if (cfg.chcfg)
               lead_d = -c3 - (c1 >>> 1);
            else if (cfg.ceref)
               lead_d = c2 - (c1 >>> 1);
            else
               lead_d = c2 - ((c1 + c3) >>> 1);
      endcase
   end

   // one register stage keeps the lead aligned with its strobe
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         lead_q <= 18'h00000;
         lead_valid_q <= 1'b0;
      end
      else
      begin
         lead_q <= smp_valid ? lead_d : lead_q;
         lead_valid_q <= smp_valid;
      end
   end
endmodule

// ==== core/pace_artifact_detector.sv ====
// Purpose: pacing-artifact detector with three lead machines and its serial registers
// Assumes: serial pins and channel samples are synchronous to clk_sys; sclk far slower
// Notes: serial frame is 32 bits, msb first: write flag, address, 24-bit data;
//        a read answers in the following frame
module pace_artifact_detector (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // 128 kHz channel samples from the decimation chain
   input pace_pkg::chan_smp_t smp,
   input wire logic smp_valid,
   // serial register port
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // frame assembly
   input wire logic frame_hdr_take,
   input wire logic frame_sel_summary,
   output logic [2:0] pace_flags,
   output logic [6:0] frame_summary,
   output logic frame_summary_en
);
   logic rst_meta_q, rst_sync_n;
   logic sclk_q, sclk_rise, sclk_fall;
   logic [4:0] bit_cnt_q, bit_cnt_d;
   logic [31:0] shin_q, shin_d, shout_q, shout_d, word;
   logic miso_q, miso_d, cmd;
   logic [6:0] addr;
   logic [23:0] rd_data;
   logic chcfg_q, chcfg_d, ceref_q, ceref_d;
   logic [11:0] ctl_q, ctl_d;
   logic [23:0] amp_q, amp_d, edge_q, edge_d, lvl_q, lvl_d;
   logic [2:0] found, flags_q, flags_d;
   pace_pkg::pace_res_t res [3];
   logic [23:0] detail_q [3];
   logic [23:0] detail_d [3];
   logic [6:0] summary_q, summary_d, fsum_q, fsum_d;
   logic fsum_en_q, fsum_en_d;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // serial shifter: mosi taken on sclk rise, miso moved on sclk fall
   always_comb
   begin
      sclk_rise = sclk && !sclk_q;
      sclk_fall = !sclk && sclk_q;
      bit_cnt_d = bit_cnt_q;
      shin_d = shin_q;
      shout_d = shout_q;
      word = {shin_q[30:0], mosi};
      cmd = 1'b0;
      addr = word[pace_pkg::ADDR_MSB:pace_pkg::ADDR_LSB];
      if (cs_n)
         bit_cnt_d = 5'h00; // a frame always starts at bit 31
      else if (sclk_rise)
      begin
         shin_d = word;
         bit_cnt_d = bit_cnt_q + 5'h01;
         cmd = (bit_cnt_q == pace_pkg::FRAME_LAST);
      end
      else if (sclk_fall && bit_cnt_q != 5'h00)
         shout_d = {shout_q[30:0], 1'b0}; // no shift after the last edge: keeps the answer
      if (cmd)
         shout_d = word[pace_pkg::WR_BIT] ? 32'h00000000 : {1'b0, addr, rd_data};
      miso_d = shout_q[31];
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sclk_q <= 1'b0;
         bit_cnt_q <= 5'h00;
         shin_q <= 32'h00000000;
         shout_q <= 32'h00000000;
         miso_q <= 1'b0;
      end
      else
      begin
         sclk_q <= sclk;
         bit_cnt_q <= bit_cnt_d;
         shin_q <= shin_d;
         shout_q <= shout_d;
         miso_q <= miso_d;
      end
   end

   // register read mux; unmapped addresses read as zero
   always_comb
   begin
      rd_data = 24'h000000;
      unique case (addr)
         pace_pkg::ADDR_ECG_CTL: rd_data[pace_pkg::CHCFG_BIT] = chcfg_q;
         pace_pkg::ADDR_CMREF_CTL: rd_data[pace_pkg::CEREF_BIT] = ceref_q;
         pace_pkg::ADDR_PACE_CTL: rd_data[11:0] = ctl_q;
         pace_pkg::ADDR_AMP_TH: rd_data = amp_q;
         pace_pkg::ADDR_EDGE_TH: rd_data = edge_q;
         pace_pkg::ADDR_LVL_TH: rd_data = lvl_q;
         pace_pkg::ADDR_SUMMARY: rd_data[6:0] = summary_q;
         pace_pkg::ADDR_DETAIL0: rd_data = detail_q[0];
         pace_pkg::ADDR_DETAIL0 + 7'h01: rd_data = detail_q[1];
         pace_pkg::ADDR_DETAIL2: rd_data = detail_q[2];
         default: rd_data = 24'h000000;
      endcase
   end

   // register writes; only the bits this block uses are kept, plus the unused ctl_q bits 10:9
   always_comb
   begin
      chcfg_d = chcfg_q;
      ceref_d = ceref_q;
      ctl_d = ctl_q;
      amp_d = amp_q;
      edge_d = edge_q;
      lvl_d = lvl_q;
      if (cmd && word[pace_pkg::WR_BIT])
      begin
         unique case (addr)
            pace_pkg::ADDR_ECG_CTL: chcfg_d = word[pace_pkg::CHCFG_BIT];
            pace_pkg::ADDR_CMREF_CTL: ceref_d = word[pace_pkg::CEREF_BIT];
            pace_pkg::ADDR_PACE_CTL: ctl_d = word[11:0];
            pace_pkg::ADDR_AMP_TH: amp_d = word[23:0];
            pace_pkg::ADDR_EDGE_TH: edge_d = word[23:0];
            pace_pkg::ADDR_LVL_TH: lvl_d = word[23:0];
            default: chcfg_d = chcfg_q; // read-only or unmapped: ignored
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         chcfg_q <= 1'b0;
         ceref_q <= 1'b0;
         ctl_q <= pace_pkg::PACE_CTL_RST;
         amp_q <= pace_pkg::AMP_TH_RST;
         edge_q <= pace_pkg::EDGE_TH_RST;
         lvl_q <= pace_pkg::LVL_TH_RST;
      end
      else
      begin
         chcfg_q <= chcfg_d;
         ceref_q <= ceref_d;
         ctl_q <= ctl_d;
         amp_q <= amp_d;
         edge_q <= edge_d;
         lvl_q <= lvl_d;
      end
   end

   // three identical machines, each with its own lead, enable and thresholds
   for (genvar i = 0; i < 3; i++)
   begin : g_mach
      pace_pkg::lead_cfg_t cfg;
      pace_pkg::thr_t thr;
      logic signed [17:0] lead;
      logic lead_valid;
      assign cfg = '{chcfg: chcfg_q, ceref: ceref_q,
         sel: pace_pkg::lead_sel_t'(ctl_q[pace_pkg::SEL_LSB + 2 * i +: 2])};
      assign thr = '{edge_th: edge_q[8 * i +: 8], lvl_th: lvl_q[8 * i +: 8],
         amp_th: amp_q[8 * i +: 8], wfilt: ctl_q[pace_pkg::WFILT_BIT]};
      lead_derive u_lead (
         .clk_sys(clk_sys),
         .rst_sync_n(rst_sync_n),
         .smp(smp),
         .smp_valid(smp_valid),
         .cfg(cfg),
         .lead_q(lead),
         .lead_valid_q(lead_valid)
      );
      pace_fsm u_fsm (
         .clk_sys(clk_sys),
         .rst_sync_n(rst_sync_n),
         .enable(ctl_q[pace_pkg::EN_LSB + i]),
         .thr(thr),
         .lead(lead),
         .lead_valid(lead_valid),
         .found_q(found[i]),
         .res_q(res[i])
      );
   end

   // header flags: a new pace wins over the header taking the old one
   always_comb
   begin
      flags_d = found | (flags_q & {3{!frame_hdr_take}});
      summary_d = summary_q;
      for (int k = 2; k >= 0; k--)
      begin
         detail_d[k] = found[k] ? 24'(res[k]) : detail_q[k];
         if (found[k])
            summary_d = {res[k].width[pace_pkg::SUM_WIDTH_LSB +: 4],
               res[k].height[pace_pkg::SUM_HEIGHT_LSB +: 3]};
      end
      fsum_en_d = frame_sel_summary;
      fsum_d = frame_sel_summary ? summary_q : 7'h00;
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         flags_q <= 3'h0;
         summary_q <= 7'h00;
         detail_q <= '{default: 24'h000000};
         fsum_q <= 7'h00;
         fsum_en_q <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         summary_q <= summary_d;
         detail_q <= detail_d;
         fsum_q <= fsum_d;
         fsum_en_q <= fsum_en_d;
      end
   end

   // outputs straight from flops
   assign miso = miso_q;
   assign pace_flags = flags_q;
   assign frame_summary = fsum_q;
   assign frame_summary_en = fsum_en_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_sync_n);
   flag_set_a: assert property (found[0] |=> flags_q[0])
      else $error("pace flag not raised");
   flag_hold_a: assert property (flags_q[1] && !frame_hdr_take && !found[1] |=> flags_q[1])
      else $error("pace flag lost before header");
   detail_store_a: assert property (found[2] |=> detail_q[2] == 24'($past(res[2])))
      else $error("detail word not stored");
   summary_store_a: assert property (found[0] |=>
      summary_q == {$past(res[0].width[8:5]), $past(res[0].height[14:12])})
      else $error("summary word not stored");
   thr_write_a: assert property (cmd && word[31] && addr == pace_pkg::ADDR_EDGE_TH |=>
      edge_q == $past(word[23:0])) else $error("edge threshold write lost");
   frame_word_a: assert property (frame_sel_summary |=> frame_summary == $past(summary_q))
      else $error("summary missing from frame");
   read_load_a: assert property (cmd && !word[31] |=> shout_q[23:0] == $past(rd_data))
      else $error("read answer not loaded");
   flag_clear_c: cover property (flags_q[0] && frame_hdr_take ##1 !flags_q[0]);
   three_found_c: cover property (found == 3'h7);
   reg_write_c: cover property (cmd && word[31]);
endmodule

// ==== core/pace_fsm.sv ====
// Purpose: one pace detection machine: leading edge, top slope, trailing edge
// Assumes: lead_valid pulses once per 128 kHz sample
// Notes: edge and level thresholds are in sample LSBs, the height threshold in steps of 2 LSBs; polarity follows the leading edge
module pace_fsm (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_sync_n,
   // control
   input wire logic enable,
   input pace_pkg::thr_t thr,
   // lead samples
   input wire logic signed [17:0] lead,
   input wire logic lead_valid,
   // result
   output logic found_q,
   output pace_pkg::pace_res_t res_q
);
   pace_pkg::fsm_state_t state_q, state_d;
   logic signed [17:0] base_q, base_d, ref_q, ref_d;
   logic neg_q, neg_d, found_d;
   logic [8:0] cnt_q, cnt_d, width;
   logic [3:0] icnt_q, icnt_d;
   logic signed [19:0] peak_q, peak_d, diff, absd, adj, step, eth, amp, lvl;
   pace_pkg::pace_res_t res_d;

   // per-sample walk through the pulse shape
   always_comb
   begin
      state_d = state_q;
      base_d = base_q;
      ref_d = ref_q;
      neg_d = neg_q;
      cnt_d = cnt_q;
      icnt_d = icnt_q;
      peak_d = peak_q;
      found_d = 1'b0;
      res_d = res_q;
      diff = 20'(lead) - 20'(base_q);
      absd = diff[19] ? -diff : diff;
      adj = neg_q ? -diff : diff;
      step = neg_q ? 20'(ref_q) - 20'(lead) : 20'(lead) - 20'(ref_q);
      eth = {12'h000, (thr.edge_th == 8'h00) ? thr.amp_th : thr.edge_th};
      amp = {11'h000, thr.amp_th, 1'b0};
      lvl = {{12{thr.lvl_th[7]}}, thr.lvl_th};
      width = cnt_q + 9'h001;
      if (!enable)
      begin
         state_d = pace_pkg::ST_IDLE;
         base_d = lead;
      end
      else if (lead_valid)
      begin
         unique case (state_q)
            pace_pkg::ST_IDLE:
            begin
               if (absd > eth)
               begin
                  state_d = pace_pkg::ST_SLOPE;
                  neg_d = diff[19];
                  ref_d = lead;
                  peak_d = absd;
                  cnt_d = 9'h000;
                  icnt_d = 4'h0;
               end
               else
                  base_d = lead; // baseline follows the signal; held once an edge starts
            end
            pace_pkg::ST_SLOPE:
            begin
               cnt_d = cnt_q + 9'h001;
               icnt_d = icnt_q + 4'h1;
               peak_d = (adj > peak_q) ? adj : peak_q;
               if (icnt_q == pace_pkg::SLOPE_INT_CNT - 4'h1)
               begin
                  icnt_d = 4'h0;
                  ref_d = lead;
                  if (step <= lvl && cnt_q > pace_pkg::TRANS_MAX_CNT)
                  begin
                     state_d = pace_pkg::ST_IDLE;
                     base_d = lead; // re-baseline, or the same slow step retriggers
                  end
                  else if (step <= lvl)
                     state_d = pace_pkg::ST_TRAIL;
               end
            end
            pace_pkg::ST_TRAIL:
            begin
               cnt_d = cnt_q + 9'h001;
               peak_d = (adj > peak_q) ? adj : peak_q;
               if (adj < eth) // opposite edge back to baseline
               begin
                  state_d = pace_pkg::ST_IDLE;
                  found_d = (peak_q >= amp) && (width <= pace_pkg::MAX_WIDTH_CNT)
                     && (!thr.wfilt || width >= pace_pkg::MIN_WIDTH_CNT);
                  res_d.width = found_d ? width : res_q.width;
                  res_d.height = !found_d ? res_q.height :
                     (peak_q > 20'(pace_pkg::HEIGHT_MAX)) ? pace_pkg::HEIGHT_MAX : peak_q[14:0];
               end
               else if (cnt_q >= pace_pkg::MAX_WIDTH_CNT)
               begin
                  state_d = pace_pkg::ST_IDLE; // too wide: always rejected
                  base_d = lead; // a long plateau becomes the new baseline
               end
            end
            default:
               state_d = pace_pkg::ST_IDLE;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_q <= pace_pkg::ST_IDLE;
         base_q <= 18'h00000;
         ref_q <= 18'h00000;
         neg_q <= 1'b0;
         cnt_q <= 9'h000;
         icnt_q <= 4'h0;
         peak_q <= 20'h00000;
         found_q <= 1'b0;
         res_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         base_q <= base_d;
         ref_q <= ref_d;
         neg_q <= neg_d;
         cnt_q <= cnt_d;
         icnt_q <= icnt_d;
         peak_q <= peak_d;
         found_q <= found_d;
         res_q <= res_d;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_sync_n);
   found_from_trail_a: assert property (found_q |-> $past(state_q) == pace_pkg::ST_TRAIL)
      else $error("pace found without a trailing edge");
   width_bounds_a: assert property (found_q |-> res_q.width <= pace_pkg::MAX_WIDTH_CNT)
      else $error("pace width above maximum");
   min_width_a: assert property (found_q && $past(thr.wfilt) |->
      res_q.width >= pace_pkg::MIN_WIDTH_CNT) else $error("pace width below minimum");
   disabled_idle_a: assert property (!enable |=> state_q == pace_pkg::ST_IDLE)
      else $error("disabled machine left idle");
   slow_edge_a: assert property (state_q == pace_pkg::ST_SLOPE && cnt_q >
      pace_pkg::TRANS_MAX_CNT |-> state_d != pace_pkg::ST_TRAIL)
      else $error("slow leading edge reached trailing search");
   pulse_found_c: cover property (found_q);
   slow_reject_c: cover property (state_q == pace_pkg::ST_SLOPE ##1 state_q == pace_pkg::ST_IDLE);
endmodule

// ==== inc/pace_pkg.sv ====
// Purpose: shared constants, types and register map of the pacing-artifact detector
// Assumes: channel samples arrive as a one-cycle strobe at the 128 kHz decimated rate
// Notes: all sample-based times except SLOPE_INT_CNT are derived from the sample rate below
package pace_pkg;
   // sample stream
   localparam int unsigned RATE_HZ = 128000;
   localparam int unsigned SMP_W = 16;
   localparam int unsigned LEAD_W = 18;
   localparam int unsigned CNT_W = 9;
   // times in microseconds and their sample counts (least rounds up, longest rounds down)
   localparam int unsigned TRANS_MAX_US = 156;
   localparam int unsigned MIN_WIDTH_US = 100;
   localparam int unsigned MAX_WIDTH_US = 2000;
   localparam logic [8:0] TRANS_MAX_CNT = 9'(TRANS_MAX_US * RATE_HZ / 1000000);
   localparam logic [8:0] MIN_WIDTH_CNT = 9'((MIN_WIDTH_US * RATE_HZ + 999999) / 1000000);
   localparam logic [8:0] MAX_WIDTH_CNT = 9'(MAX_WIDTH_US * RATE_HZ / 1000000);
   localparam logic [3:0] SLOPE_INT_CNT = 4'h2;
   // serial frame: write flag, 7-bit address, 24-bit data
   localparam logic [4:0] FRAME_LAST = 5'h1F;
   localparam int unsigned ADDR_MSB = 30;
   localparam int unsigned ADDR_LSB = 24;
   localparam int unsigned WR_BIT = 31;
   // register offsets
   localparam logic [6:0] ADDR_ECG_CTL = 7'h01;
   localparam logic [6:0] ADDR_PACE_CTL = 7'h04;
   localparam logic [6:0] ADDR_CMREF_CTL = 7'h05;
   localparam logic [6:0] ADDR_AMP_TH = 7'h07;
   localparam logic [6:0] ADDR_EDGE_TH = 7'h0E;
   localparam logic [6:0] ADDR_LVL_TH = 7'h0F;
   localparam logic [6:0] ADDR_SUMMARY = 7'h1A;
   localparam logic [6:0] ADDR_DETAIL0 = 7'h3A;
   localparam logic [6:0] ADDR_DETAIL2 = 7'h3C;
   // field positions
   localparam int unsigned CHCFG_BIT = 10;
   localparam int unsigned CEREF_BIT = 8;
   localparam int unsigned EN_LSB = 0;
   localparam int unsigned SEL_LSB = 3;
   localparam int unsigned WFILT_BIT = 11;
   localparam int unsigned CTL_W = 12;
   localparam int unsigned SUM_WIDTH_LSB = 5;
   localparam int unsigned SUM_HEIGHT_LSB = 12;
   // reset values, height limit and lead selection codes
   localparam logic [23:0] AMP_TH_RST = 24'h242424;
   localparam logic [23:0] EDGE_TH_RST = 24'h000000;
   localparam logic [23:0] LVL_TH_RST = 24'h000000;
   localparam logic [11:0] PACE_CTL_RST = 12'hE00;
   localparam logic [14:0] HEIGHT_MAX = 15'h7FFF;
   typedef enum logic [1:0] {LEAD_I = 2'h0, LEAD_II = 2'h1, LEAD_III = 2'h2, LEAD_AVF = 2'h3}
      lead_sel_t;
   // gray along idle -> slope -> trail; code 2'b10 is illegal
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SLOPE = 2'b01, ST_TRAIL = 2'b11} fsm_state_t;
   typedef struct packed {
      logic signed [15:0] ch1;
      logic signed [15:0] ch2;
      logic signed [15:0] ch3;
   } chan_smp_t;
   typedef struct packed {
      logic chcfg;
      logic ceref;
      lead_sel_t sel;
   } lead_cfg_t;
   typedef struct packed {
      logic [7:0] edge_th;
      logic signed [7:0] lvl_th;
      logic [7:0] amp_th;
      logic wfilt;
   } thr_t;
   typedef struct packed {
      logic [8:0] width;
      logic [14:0] height;
   } pace_res_t;
endpackage

// ==== sim/pace_host.sv ====
// Purpose: serial host model that reads and writes the detector registers
// Assumes: mode 0, sclk idles low, each sclk level lasts 4 clk_sys
// Notes: a read answer comes back in the frame after the request
module pace_host (
   // clock
   input wire logic clk_sys,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle pins; sclk stands still low between frames
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // one frame msb first; miso is taken just before each rise
   task automatic frame(input logic [31:0] w, output logic [31:0] r);
      @(posedge clk_sys) #1 cs_n = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         mosi = w[i];
         repeat (4) @(posedge clk_sys);
         r[i] = miso;
         #1 sclk = 1'b1;
         repeat (4) @(posedge clk_sys);
         #1 sclk = 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      #1 cs_n = 1'b1;
      mosi = ~w[0]; // no pull on mosi: never leave the last bit showing
      repeat (3) @(posedge clk_sys);
   endtask
   // register write
   task automatic wr(input logic [6:0] a, input logic [23:0] d);
      logic [31:0] r;
      frame({1'b1, a, d}, r);
   endtask
   // register read: request, then a second frame carries the answer
   task automatic rd(input logic [6:0] a, output logic [23:0] d);
      logic [31:0] r;
      frame({1'b0, a, 24'h000000}, r);
      frame({1'b0, a, 24'h000000}, r);
      d = r[23:0];
   endtask
endmodule

// ==== sim/test_pace_artifact_detector.sv ====
// Purpose: self-checking bench for the pace detector
// Assumes: one sample every 4 clocks, far faster than real, which the machines allow
// Notes: machine 0 edge threshold stays 0 so it runs at half the height threshold
module test_pace_artifact_detector;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, smp_valid, sclk, cs_n, mosi, miso, frame_hdr_take;
   logic frame_sel_summary, frame_summary_en;
   logic [2:0] pace_flags;
   logic [6:0] frame_summary;
   pace_pkg::chan_smp_t smp;
   int num_errors = 0;
   int cmp_count = 0;
   pace_artifact_detector pace_artifact_detector_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .smp(smp), .smp_valid(smp_valid), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .frame_hdr_take(frame_hdr_take), .frame_sel_summary(frame_sel_summary),
      .pace_flags(pace_flags), .frame_summary(frame_summary),
      .frame_summary_en(frame_summary_en));
   pace_host pace_host_i (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso));
   // comparison and verdict
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one sample strobe
   task automatic send(input pace_pkg::chan_smp_t s);
      @(posedge clk_sys) #1 smp = s;
      smp_valid = 1'b1;
      @(posedge clk_sys) #1 smp_valid = 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   function automatic pace_pkg::chan_smp_t scl(pace_pkg::chan_smp_t t, int k, int n);
      return '{16'(t.ch1 * k / n), 16'(t.ch2 * k / n), 16'(t.ch3 * k / n)};
   endfunction
   // ramp up in n steps, hold, ramp down; long idle lets any candidate time out
   task automatic pulse(input pace_pkg::chan_smp_t t, input int n, input int hold);
      for (int k = 1; k <= n; k++)
         send(scl(t, k, n));
      repeat (hold) send(t);
      for (int k = n - 1; k >= 0; k--)
         send(scl(t, k, n));
      repeat (300) send('0);
   endtask
   // header flags, then a header take must clear them
   task automatic flags(input logic [2:0] e);
      check(24'(pace_flags), 24'(e));
      @(posedge clk_sys) #1 frame_hdr_take = 1'b1;
      @(posedge clk_sys) #1 frame_hdr_take = 1'b0;
      repeat (2) @(posedge clk_sys);
      check(24'(pace_flags), 24'h000000);
   endtask
   task automatic ctl(input logic [2:0] en, input logic [1:0] sel, input logic wf);
      pace_host_i.wr(7'h04, {12'h000, wf, 2'b11, 4'h0, sel, en});
   endtask
   task automatic t_regs();
      logic [23:0] d;
      pace_host_i.rd(7'h07, d);
      check(d, 24'h242424);
      pace_host_i.rd(7'h0F, d);
      check(d, 24'h000000);
      pace_host_i.rd(7'h04, d);
      check(d, 24'h000E00);
      pace_host_i.wr(7'h3A, 24'h123456);
      pace_host_i.rd(7'h3A, d);
      check(d, 24'h000000);
      pace_host_i.wr(7'h0E, 24'h3C1400);
      pace_host_i.rd(7'h0E, d);
      check(d, 24'h3C1400);
      pace_host_i.wr(7'h07, 24'h32FF32);
      pace_host_i.wr(7'h0F, 24'h050505);
   endtask
   // every lead of every channel configuration, height read back in detail
   task automatic t_leads();
      logic [23:0] d;
      int e [3][4] = '{'{1000, 1600, 600, 1100}, '{400, 1000, 600, 800}, '{400, 600, 1000, 400}};
      for (int c = 0; c < 3; c++)
         for (int s = 0; s < 4; s++)
         begin
            pace_host_i.wr(7'h01, (c == 2) ? 24'h000400 : 24'h000000);
            pace_host_i.wr(7'h05, (c == 1) ? 24'h000100 : 24'h000000);
            ctl(3'b001, 2'(s), 1'b1);
            pulse('{16'sd400, 16'sd1000, -16'sd600}, 1, 20);
            flags(3'b001);
            pace_host_i.rd(7'h3A, d);
            check({9'h000, d[14:0]}, 24'(e[c][s]));
         end
      // all three machines at once, each on its own lead and thresholds
      pace_host_i.wr(7'h04, 24'h000727);
      pulse('{16'sd400, 16'sd1000, -16'sd600}, 1, 20);
      flags(3'b111);
      for (int m = 1; m < 3; m++)
      begin
         pace_host_i.rd(7'h3A + 7'(m), d);
         check({9'h000, d[14:0]}, 24'(400 * m + 200));
      end
   endtask
   task automatic t_gates();
      logic [23:0] d;
      pace_pkg::chan_smp_t p = '{16'sd300, 16'sd0, 16'sd0};
      ctl(3'b011, 2'b00, 1'b1);
      pulse(p, 1, 20);
      flags(3'b001);
      pulse(p, 1, 5);
      flags(3'b000);
      ctl(3'b001, 2'b00, 1'b0);
      pulse(p, 1, 5);
      flags(3'b001);
      pulse(p, 1, 300);
      flags(3'b000);
      // steps of 60 start an edge, but 25 samples of rise is too slow a transition
      pulse('{16'sd1500, 16'sd0, 16'sd0}, 25, 20);
      flags(3'b000);
      // edge threshold 0 acts as 50 here: steps of 60 start a pulse, steps of 20 do not
      pulse(p, 5, 20);
      flags(3'b001);
      pulse(p, 15, 20);
      flags(3'b000);
      pulse('{-16'sd1000, 16'sd0, 16'sd0}, 1, 20);
      flags(3'b001);
      ctl(3'b001, 2'b00, 1'b1);
      pulse('{16'sd10000, 16'sd0, 16'sd0}, 1, 20);
      pace_host_i.rd(7'h1A, d);
      check(d, 24'h000002);
      @(posedge clk_sys) #1 frame_sel_summary = 1'b1;
      @(posedge clk_sys) #1 frame_sel_summary = 1'b0;
      check(24'({frame_summary_en, frame_summary}), 24'h000082);
      flags(3'b001);
      ctl(3'b000, 2'b00, 1'b1);
      pulse(p, 1, 20);
      flags(3'b000);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // watchdog well beyond the expected run
   initial
   begin
      #900000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      rst_n = 1'b0;
      smp = '0;
      smp_valid = 1'b0;
      frame_hdr_take = 1'b0;
      frame_sel_summary = 1'b0;
      repeat (12) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      t_regs();
      t_leads();
      t_gates();
      wrap_up();
   end
endmodule
